// File: core/mii_consts.vh
// Timing constants for the nibble link as seen from the physical layer side
`ifndef MII_CONSTS_VH
`define MII_CONSTS_VH

// Reference clock period, ns
`define MII_REF_PERIOD_NS 8
// Nominal nibble clock period at 100 Mb/s (25 MHz) and at 10 Mb/s (2.5 MHz), ns
`define MII_NIB_PERIOD_100_NS 40
`define MII_NIB_PERIOD_10_NS 400
// Reference cycles per nibble clock period
`define MII_DIV_100 (`MII_NIB_PERIOD_100_NS / `MII_REF_PERIOD_NS)
`define MII_DIV_10 (`MII_NIB_PERIOD_10_NS / `MII_REF_PERIOD_NS)
// Counter width for the clock divider
`define MII_CNT_W 6
// Receive buffer word: error flag and nibble
`define MII_RXW 5
// Speed after reset: 1 selects 100 Mb/s
`define MII_SPD_RST 1'b1

`endif

// File: core/mii_phy_link.v
// Physical layer end of the nibble link: clock generation, transmit capture, receive delivery, carrier
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RL1: Receiving side reports a frame check error when receive error flags a frame.
// RL2: Transmit clock is bit rate over four: 25 MHz or 2.5 MHz.
// RL3: Receive clock is received bit rate over four, matching current speed.
// RL4: While receiving, receive clock follows recovered line clock; nibbles synchronous to it.
// RL5: On lost signal, receive clock runs from the local transmit clock reference.
// RL6: Receive clock source may change only while receive data valid is low.
// RL7: After valid drops, no receive clock phase exceeds two nominal periods.
// RL8: Transmit enable rises together with the first preamble nibble.
// RL9: Transmit enable stays high until every frame nibble is presented.
// RL10: Transmit enable and data change only with transmit clock; enable drops promptly.
// RL11: Far end registers transmit outputs and synchronises receive inputs.
// RL12: Clock rate follows configured speed and changes only with no frame in transfer.
// RL13: Transmit error with enable at 100 Mb/s emits an invalid symbol, else ignored.
// RL14: Receive data valid spans first to last nibble, changing with receive clock.
// RL15: Carrier sense high when transmit or receive busy, through collisions.
// RL16: Collision indication high while a collision on the medium persists.

module mii_fifo2 #(
  parameter WIDTH = 5
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wptr_reg;
  reg rptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
    if (rst) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wptr_reg <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule // mii_fifo2

module mii_phy_link (
  input wire ref_clk,
  input wire rst,
  input wire spd_100_cfg,
  output wire tx_clk,
  input wire tx_en,
  input wire [3:0] txd,
  input wire tx_er,
  output wire rx_clk,
  output wire rx_dv,
  output wire [3:0] rxd,
  output wire rx_er,
  output wire crs,
  output wire col,
  output wire line_tx_valid,
  output wire [3:0] line_tx_nibble,
  output wire line_tx_invalid,
  input wire line_rx_valid,
  output wire line_rx_ready,
  input wire [3:0] line_rx_nibble,
  input wire line_rx_err,
  input wire line_rec_clk,
  input wire line_sig_ok,
  input wire line_rx_busy,
  input wire line_col_det
);
`include "mii_consts.vh"

  // Divider lengths held as integers, cut to the counter width where they are used
  localparam integer DIV_100_I = `MII_DIV_100;
  localparam integer DIV_10_I = `MII_DIV_10;

  reg spd_reg;
  reg [`MII_CNT_W-1:0] cnt_reg;
  reg [`MII_CNT_W-1:0] cnt_next;
  reg tx_clk_reg;
  reg tx_en_s1_reg;
  reg tx_en_s2_reg;
  reg [3:0] txd_s1_reg;
  reg [3:0] txd_s2_reg;
  reg tx_er_s1_reg;
  reg tx_er_s2_reg;
  reg rec_s1_reg;
  reg rec_s2_reg;
  reg tx_active_reg;
  reg ltx_valid_reg;
  reg [3:0] ltx_nibble_reg;
  reg ltx_invalid_reg;
  reg use_rec_reg;
  reg rx_clk_reg;
  reg rx_dv_reg;
  reg [3:0] rxd_reg;
  reg rx_er_reg;
  reg crs_reg;
  reg col_reg;
  wire [`MII_CNT_W-1:0] div_now;
  wire [`MII_CNT_W-1:0] high_cnt;
  wire wrap;
  wire rx_src;
  wire rx_fall;
  wire fifo_valid;
  wire [`MII_RXW-1:0] fifo_data;
  wire col_now;

  // Divider sets the nibble clock rate from the current speed
  assign div_now = spd_reg ? DIV_100_I[`MII_CNT_W-1:0] : DIV_10_I[`MII_CNT_W-1:0]; // RL2
  assign high_cnt = {1'b0, div_now[`MII_CNT_W-1:1]};
  assign wrap = (cnt_reg == div_now - 6'h01);

  always @* begin
    cnt_next = wrap ? 6'h00 : cnt_reg + 6'h01;
  end

  // Receive clock source: recovered line clock while locked, else the transmit reference
  assign rx_src = use_rec_reg ? rec_s2_reg : tx_clk_reg; // RL3 RL4 RL5
  assign rx_fall = rx_clk_reg & ~rx_src;
  assign col_now = line_col_det | (tx_active_reg & line_rx_busy);

  mii_fifo2 #(
    .WIDTH(`MII_RXW)
  ) u_rx_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(line_rx_valid),
    .in_ready(line_rx_ready),
    .in_data({line_rx_err, line_rx_nibble}),
    .out_valid(fifo_valid),
    .out_ready(rx_fall),
    .out_data(fifo_data)
  );

  always @(posedge ref_clk) begin
    // Pins from the far end pass two flops before anything looks at them
    tx_en_s1_reg <= tx_en;
    tx_en_s2_reg <= tx_en_s1_reg;
    txd_s1_reg <= txd;
    txd_s2_reg <= txd_s1_reg;
    tx_er_s1_reg <= tx_er;
    tx_er_s2_reg <= tx_er_s1_reg;
    rec_s1_reg <= line_rec_clk;
    rec_s2_reg <= rec_s1_reg;
    if (rst) begin
      spd_reg <= `MII_SPD_RST;
      cnt_reg <= 6'h00;
      tx_clk_reg <= 1'b1;
      tx_active_reg <= 1'b0;
      ltx_valid_reg <= 1'b0;
      ltx_nibble_reg <= 4'h0;
      ltx_invalid_reg <= 1'b0;
      use_rec_reg <= 1'b0;
      rx_clk_reg <= 1'b1;
      rx_dv_reg <= 1'b0;
      rxd_reg <= 4'h0;
      rx_er_reg <= 1'b0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tx_clk_reg <= (cnt_next < high_cnt); // RL2
      // Rate changes only on a period boundary with both directions idle
      if (wrap & ~tx_active_reg & ~tx_en_s2_reg & ~rx_dv_reg & ~fifo_valid) begin
        spd_reg <= spd_100_cfg; // RL12
      end
      // Capture the nibble that stood before the rising edge about to be driven
      ltx_valid_reg <= 1'b0;
      ltx_invalid_reg <= 1'b0;
      if (wrap) begin
        tx_active_reg <= tx_en_s2_reg; // RL8 RL9 RL10
        ltx_valid_reg <= tx_en_s2_reg;
        ltx_nibble_reg <= txd_s2_reg;
        ltx_invalid_reg <= tx_en_s2_reg & tx_er_s2_reg & spd_reg; // RL13
      end
      // Swap source only when idle and both clocks sit at the same level, so no runt or long phase
      if (~rx_dv_reg & ~fifo_valid & (use_rec_reg != line_sig_ok) & (rec_s2_reg == tx_clk_reg)) begin
        use_rec_reg <= line_sig_ok; // RL6 RL7
      end
      rx_clk_reg <= rx_src; // RL4
      // Receive outputs change on the falling edge, so the far end samples them stable
      if (rx_fall) begin
        rx_dv_reg <= fifo_valid; // RL14
        rxd_reg <= fifo_valid ? fifo_data[3:0] : 4'h0;
        rx_er_reg <= fifo_valid & fifo_data[4]; // RL1
      end
      col_reg <= col_now; // RL16
      crs_reg <= tx_active_reg | line_rx_busy | col_now; // RL15
    end
  end

  assign tx_clk = tx_clk_reg;
  assign rx_clk = rx_clk_reg;
  assign rx_dv = rx_dv_reg;
  assign rxd = rxd_reg;
  assign rx_er = rx_er_reg;
  assign crs = crs_reg;
  assign col = col_reg;
  assign line_tx_valid = ltx_valid_reg;
  assign line_tx_nibble = ltx_nibble_reg;
  assign line_tx_invalid = ltx_invalid_reg;
endmodule // mii_phy_link

`default_nettype wire

// File: testbench/mii_mac_model.sv
// MAC side model driving one frame per request
`timescale 1ns/100ps
`default_nettype none
module mii_mac_model (
  input wire logic tx_clk,
  input wire logic [3:0] req,
  output logic tx_en = 1'b0,
  output logic [3:0] txd = 4'h0,
  output logic tx_er = 1'b0
);
  logic [3:0] left = 4'h0;
  logic [3:0] ack = 4'h0;
  // Launched from tx_clk so the far end never sees a mid-period change
  always @(posedge tx_clk) begin
    tx_er <= left == 4'h2;
    if (left != 4'h0) begin
      txd <= txd + 4'h1;
      left <= left - 4'h1;
    end else if (req != ack) begin
      {tx_en, txd, left, ack} <= {1'b1, 4'h5, 4'h5, req};
    end else begin
      tx_en <= 1'b0;
      txd <= ~txd;
    end
  end
endmodule // mii_mac_model
`default_nettype wire

// File: testbench/mii_link_monitor.sv
// Port checks for the nibble link physical layer end
`timescale 1ns/100ps
`default_nettype none
module mii_link_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spd_100_cfg,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic col,
  input wire logic line_tx_valid,
  input wire logic line_tx_invalid,
  input wire logic line_sig_ok,
  input wire logic line_rx_busy,
  input wire logic line_col_det
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence hi2_lo3;
    tx_clk [*2] ##1 !tx_clk [*3] ##1 tx_clk;
  endsequence
  // Fast rate only; a speed change lands on a wrap, so the rise after it already has the new shape
  tx_rate_a: assert property (spd_100_cfg && $rose(tx_clk) |-> hi2_lo3) else $error("tx clock");
  capture_pulse_a: assert property (line_tx_valid |-> $rose(tx_clk) ##1 !line_tx_valid) else $error("capture");
  invalid_symbol_a: assert property (line_tx_invalid |-> line_tx_valid) else $error("invalid");
  rx_dv_sync_a: assert property ($changed(rx_dv) |-> $fell(rx_clk)) else $error("rx_dv edge");
  crs_busy_a: assert property (line_rx_busy |=> crs) else $error("crs");
  crs_drop_a: assert property ($fell(crs) |-> !$past(line_rx_busy)) else $error("crs drop");
  col_det_a: assert property (line_col_det |=> col) else $error("col");
  // Only after the signal has been gone a while, so a line clock phase is not judged
  rx_phase_a: assert property (!$past(line_sig_ok, 16) && !line_sig_ok && !rx_dv && $changed(rx_clk) |->
    ##[1:10] $changed(rx_clk)) else $error("rx phase");
endmodule // mii_link_monitor
bind mii_phy_link mii_link_monitor mon (.ref_clk, .rst, .spd_100_cfg, .tx_clk, .rx_clk, .rx_dv, .crs, .col, .line_tx_valid,
  .line_tx_invalid, .line_sig_ok, .line_rx_busy, .line_col_det);
`default_nettype wire

// File: testbench/mii_nibble_link_signalling_tb.sv
// Bench for the physical layer end of the nibble link
`timescale 1ns/100ps
`default_nettype none
module mii_nibble_link_signalling_tb;
  logic ref_clk = 1'b0, rst = 1'b1, line_rec_clk = 1'b0, line_rx_valid = 1'b0, line_rx_err = 1'b0;
  logic line_sig_ok = 1'b1, line_rx_busy = 1'b0, line_col_det = 1'b0;
  logic spd_cfg = 1'b1;
  logic [4:0] k = 5'h00;
  logic [3:0] line_rx_nibble = 4'h0, req = 4'h0, n = 4'h0, m = 4'h0;
  logic [4:0] rows[6] = '{5'h03, 5'h1c, 5'h05, 5'h0a, 5'h10, 5'h1f};
  int error_cnt = 0, comparisons = 0;
  wire tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er, crs, col, line_tx_valid, line_tx_invalid, line_rx_ready;
  wire [3:0] txd, rxd, line_tx_nibble;
  mii_phy_link dut (.ref_clk, .rst, .spd_100_cfg(spd_cfg), .tx_clk, .tx_en, .txd, .tx_er, .rx_clk, .rx_dv, .rxd,
    .rx_er, .crs, .col, .line_tx_valid, .line_tx_nibble, .line_tx_invalid, .line_rx_valid, .line_rx_ready,
    .line_rx_nibble, .line_rx_err, .line_rec_clk, .line_sig_ok, .line_rx_busy, .line_col_det);
  mii_mac_model mac (.tx_clk, .req, .tx_en, .txd, .tx_er);
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] seen);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  initial #3 forever #80 line_rec_clk = ~line_rec_clk;
  always @(posedge rx_clk) if (rx_dv) begin
    chk("rx_word", rows[n], {rx_er, rxd});
    n <= n + 4'h1;
  end
  always @(posedge ref_clk) if (line_tx_valid) begin
    chk("tx_nibble", {m == 4'h4, 4'h5 + m}, {line_tx_invalid, line_tx_nibble});
    m <= m + 4'h1;
  end
  initial begin
    #60000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    chk("reset", 5'h19, {tx_clk, rx_clk, rx_dv, line_tx_valid, line_rx_ready});
    rst = 1'b0;
    line_rx_busy = 1'b1;
    // Offered every cycle, so the buffer fills and must refuse without losing a word
    foreach (rows[i]) begin
      {line_rx_valid, line_rx_err, line_rx_nibble} = {1'b1, rows[i]};
      while (!line_rx_ready) @(negedge ref_clk);
      @(negedge ref_clk);
    end
    line_rx_valid = 1'b0;
    wait (n == 4'h6);
    @(negedge ref_clk);
    line_rx_busy = 1'b0;
    req = 4'h1;
    wait (m == 4'h6);
    @(negedge ref_clk);
    // Slow rate: the high phase of the transmit clock must be half of a 2.5 MHz period
    spd_cfg = 1'b0;
    repeat (120) @(negedge ref_clk);
    @(posedge tx_clk);
    @(negedge ref_clk);
    k = 5'h00;
    while (tx_clk) begin
      k = k + 5'h01;
      @(negedge ref_clk);
    end
    chk("slow_high", 5'h19, k);
    spd_cfg = 1'b1;
    repeat (120) @(negedge ref_clk);
    line_col_det = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("collision", 5'h03, {3'h0, col, crs});
    {line_col_det, line_sig_ok} = 2'b00;
    repeat (200) @(negedge ref_clk);
    report_and_stop();
  end
endmodule // mii_nibble_link_signalling_tb
`default_nettype wire
